// [bench/clock_mode_and_fifo_sync_ctrl_test.sv]
// Purpose: Self-checking bench of the clock mode and FIFO sync control
// Assumes: Register port strobes one cycle; read data stands one cycle
// Notes:   Sample tick is 128 ns against a 125 ns data clock, so gap drifts
`timescale 1ns/10ps
module clock_mode_and_fifo_sync_ctrl_test;
	import cmfs_pkg::*;
	// ==========================================================
	// Stimulus and observed signals
	logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, osr = 1'b0;
	logic        sreq = 1'b0, frz = 1'b0, frq = 1'b0, dclk, frm, syn, pth, pdn, sval, msync;
	logic [7:0]  addr = 8'h00, rdv;
	logic [15:0] wdat = 16'h0000, rdat, q;
	logic [2:0]  lfv = 3'h5;
	logic [31:0] dat, sdat;
	logic [3:0]  pdiv;
	logic [1:0]  cp;
	logic [5:0]  ct;
	int          num_errors = 0, compares = 0, cyc = 0, t0, i;
	logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
	logic [15:0] rv [7] = '{16'h0001, 16'h0011, 16'h0158, 16'h0040, 16'h0004, 16'h0004, 16'h0000};
	// ==========================================================
	// Design and data source
	cmfs_ctrl uut (.core_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdat),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .input_data_clock_i(dclk),
		.data_i(dat), .frame_strobe_i(frm), .sync_strobe_i(syn), .output_strobe_i(osr),
		.pll_loop_volt_i(lfv), .pll_path_sel_o(pth), .pll_power_down_o(pdn),
		.prescale_div_o(pdiv), .charge_pump_select_o(cp), .coarse_tune_o(ct),
		.ref_div_o(rdv), .sample_data_o(sdat), .sample_valid_o(sval), .mixer_sync_o(msync));
	cmfs_source src (.sync_req_i(sreq), .freeze_i(frz), .frame_req_i(frq), .data_clk_o(dclk),
		.data_o(dat), .sync_o(syn), .frame_o(frm));
	// ==========================================================
	// Clock and hang guard; the whole run needs well under 20000 cycles
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			wrap_up();
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Write, then let the register copy and its decode settle
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		q = rdat;
	endtask
	// Count cycles until a resync pulse, giving up at the limit
	task automatic wait_sync(input int lim);
		t0 = 0;
		while (msync !== 1'b1 && t0 < lim) begin
			@(posedge clk);
			#1;
			t0++;
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Test sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// Reset values, loop voltage readback and an unmapped address
		for (i = 0; i < 7; i++) begin
			rreg(ra[i]);
			check(q, rv[i]);
		end
		check({pth, pdn, pdiv, cp, rdv}, {1'b0, 1'b1, 4'h4, 2'h1, 8'h04});
		// Prescale decode for every documented code
		for (i = 4; i < 8; i++) begin
			wreg(8'h08, 16'h0010 | 16'(i << 1));
			check(pdiv, (i == 7) ? 8 : i);
		end
		// PLL mode with double charge pump, coarse tune and divider M; P times M is 32
		wreg(8'h10, 16'h0008);
		check(rdv, 8'h08);
		wreg(8'h08, 16'h0039);
		check({pth, cp}, {1'b1, 2'h3});
		wreg(8'h0C, 16'h002A);
		check({pdn, ct}, {1'b0, 6'h2A});
		wreg(8'h08, 16'h0018);
		wreg(8'h0C, 16'h0040);
		check({pth, pdn}, {1'b0, 1'b1});
		lfv <= 3'h2;
		repeat (4) @(posedge clk);
		rreg(8'h08);
		check(q[8:6], 3'h2);
		// Single source sync from one sync strobe edge
		sreq <= 1'b1;
		wait_sync(400);
		check(t0 < 400, 1);
		sreq <= 1'b0;
		wreg(8'h18, 16'h0007);
		rreg(8'h18);
		check(q[0], 1'b0);
		// Faster writes drift the gap until read and write collide
		t0 = 0;
		q = 16'h0000;
		while (q[0] !== 1'b1 && t0 < 3000) begin
			rreg(8'h18);
			t0++;
		end
		check(q[2:0], 3'h7);
		// Resync from the frame strobe and clear restore a clean gap
		wreg(8'h04, 16'h0022);
		frq <= 1'b1;
		wait_sync(400);
		check(t0 < 400, 1);
		frq <= 1'b0;
		wreg(8'h18, 16'h0007);
		rreg(8'h18);
		check(q[0], 1'b0);
		// Bypass: no resync pulse and data passes straight through
		frz <= 1'b1;
		wreg(8'h00, 16'h0000);
		sreq <= 1'b1;
		frq <= 1'b1;
		wait_sync(600);
		check(t0, 600);
		sreq <= 1'b0;
		frq <= 1'b0;
		@(posedge sval);
		@(posedge clk);
		#1;
		check(sdat, dat);
		check(sval, 1'b0);
		// Dual source: output strobe resets the read pointer
		frz <= 1'b0;
		wreg(8'h00, 16'h0001);
		wreg(8'h04, 16'h0014);
		osr <= 1'b1;
		wait_sync(40);
		check(t0 < 40, 1);
		osr <= 1'b0;
		// PLL path: internal strobe every M sample ticks
		wreg(8'h08, 16'h0019);
		wait_sync(200);
		@(posedge clk);
		#1;
		wait_sync(200);
		check(t0 + 1, 128);
		wrap_up();
	end
endmodule

// [bench/cmfs_source.sv]
// Purpose: Behavioural data source driving data clock, data and strobes
// Assumes: Data clock runs free at 125 ns; data changes on falling edges
// Notes:   Frame and sync strobes follow bench requests, one rising edge per resync
`timescale 1ns/10ps
module cmfs_source (
	// Bench controls
	input  wire logic        sync_req_i,
	input  wire logic        freeze_i,
	input  wire logic        frame_req_i,
	// Source pins
	output logic             data_clk_o,
	output logic [31:0]      data_o,
	output logic             sync_o,
	output logic             frame_o
);
	// ==========================================================
	// Data clock and pin start values
	initial begin
		data_clk_o = 1'b0;
		data_o = 32'hA5A50000;
		sync_o = 1'b0;
		frame_o = 1'b0;
	end
	// Separate data clock for the write side
	always #62.5 data_clk_o = ~data_clk_o;
	// Launch on falling edge so data is stable at the capturing edge
	always @(negedge data_clk_o) begin
		sync_o <= sync_req_i; // Bench raises once per resync
		frame_o <= frame_req_i; // Alternative single resync source
		if (!freeze_i) begin
			data_o <= data_o + 32'h00000001;
		end
	end
endmodule

// [hdl/cmfs_ctrl.sv]
// Purpose: Sample clock mode control, PLL settings and input FIFO pointer synchronisation
// Assumes: Data clock, strobes, data and loop voltage are asynchronous pins, sampled by core_clk_i
// Notes:   Sample clock is modelled as a one-cycle tick from a core clock divider
`timescale 1ns/10ps
module cmfs_ctrl
	import cmfs_pkg::*;
(
	// Clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 reset_n_i,
	// Register port
	input  wire logic [7:0]           reg_addr_i,
	input  wire logic [REG_W-1:0]     reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic      [REG_W-1:0]     reg_rdata_o,
	// Data source pins
	input  wire logic                 input_data_clock_i,
	input  wire logic [DATA_W-1:0]    data_i,
	input  wire logic                 frame_strobe_i,
	input  wire logic                 sync_strobe_i,
	input  wire logic                 output_strobe_i,
	// PLL analog side
	input  wire logic [LFV_W-1:0]     pll_loop_volt_i,
	output logic                      pll_path_sel_o,
	output logic                      pll_power_down_o,
	output logic      [3:0]           prescale_div_o,
	output logic      [1:0]           charge_pump_select_o,
	output logic      [5:0]           coarse_tune_o,
	output logic      [7:0]           ref_div_o,
	// Sample domain data path
	output logic      [DATA_W-1:0]    sample_data_o,
	output logic                      sample_valid_o,
	output logic                      mixer_sync_o
);
	// ==========================================================
	// Reset release and pin synchronisers
	logic              rst_s1_reg;
	logic              rst_n;
	logic [SYNC_W-1:0] pin_s1_reg;
	logic [SYNC_W-1:0] pin_s2_reg;
	logic [SYNC_W-1:0] pin_in;

	// Gather the pins in one vector so every bit takes the same two-flop path
	assign pin_in = {pll_loop_volt_i, data_i, output_strobe_i, sync_strobe_i,
		frame_strobe_i, input_data_clock_i};

	// Release reset through two flops so all state leaves reset together
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	// Every pin bit passes two flops; only the second stage is read
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_pin_sync
			always_ff @(posedge core_clk_i or negedge rst_n) begin
				if (!rst_n) begin
					pin_s1_reg[gi] <= 1'b0;
					pin_s2_reg[gi] <= 1'b0;
				end else begin
					pin_s1_reg[gi] <= pin_in[gi];
					pin_s2_reg[gi] <= pin_s1_reg[gi];
				end
			end
		end
	endgenerate

	logic              dclk_s;
	logic              frame_s;
	logic              sync_s;
	logic              output_strobe_ext_s;
	logic [DATA_W-1:0] data_s;
	logic [LFV_W-1:0]  lfv_s;
	assign dclk_s     = pin_s2_reg[0];
	assign frame_s    = pin_s2_reg[1];
	assign sync_s     = pin_s2_reg[2];
	assign output_strobe_ext_s = pin_s2_reg[3];
	assign data_s     = pin_s2_reg[4 +: DATA_W];
	assign lfv_s      = pin_s2_reg[4 + DATA_W +: LFV_W];

	// ==========================================================
	// Prescale decode
	function automatic logic [3:0] prescale_decode(input logic [2:0] sel);
		case (sel)
			3'h7:    prescale_decode = 4'h8;
			3'h6:    prescale_decode = 4'h6;
			3'h5:    prescale_decode = 4'h5;
			default: prescale_decode = 4'h4;
		endcase
	endfunction

	// ==========================================================
	// State
	logic              fifo_use_reg,  fifo_use_next;
	logic [3:0]        rd_sel_reg,    rd_sel_next;
	logic [3:0]        wr_sel_reg,    wr_sel_next;
	logic              pll_path_reg,  pll_path_next;
	logic              pll_sleep_reg, pll_sleep_next;
	logic [2:0]        prescale_reg,  prescale_next;
	logic [1:0]        cp_reg,        cp_next;
	logic [5:0]        coarse_reg,    coarse_next;
	logic [7:0]        ref_div_reg,   ref_div_next;
	logic [2:0]        fifo_ofs_reg,  fifo_ofs_next;
	logic [2:0]        alarm_reg,     alarm_next;
	logic [REG_W-1:0]  rdata_reg,     rdata_next;
	logic [3:0]        prediv_reg,    prediv_next;
	logic              tick_reg,      tick_next;
	logic [7:0]        m_cnt_reg,     m_cnt_next;
	logic              output_strobe_int_reg,  output_strobe_int_next;
	logic              dclk_d_reg,    dclk_d_next;
	logic              wstb_d_reg,    wstb_d_next;
	logic              rstb_d_reg,    rstb_d_next;
	logic              rd_pend_reg,   rd_pend_next;
	logic [PTR_W-1:0]  wr_ptr_reg,    wr_ptr_next;
	logic [PTR_W-1:0]  rd_ptr_reg,    rd_ptr_next;
	logic [DATA_W-1:0] out_reg,       out_next;
	logic              valid_reg,     valid_next;
	logic              msync_reg,     msync_next;
	logic [DATA_W-1:0] mem [FIFO_DEPTH];

	cmfs_mode_t        mode;
	logic              dclk_rise;
	logic              wr_strobe;
	logic              wr_sync;
	logic              rd_strobe;
	logic              rd_sync;
	logic [2:0]        gap;

	// ==========================================================
	// Next state: registers, clock mode, pointers and alarms
	always_comb begin
		fifo_use_next  = fifo_use_reg;
		rd_sel_next    = rd_sel_reg;
		wr_sel_next    = wr_sel_reg;
		pll_path_next  = pll_path_reg;
		pll_sleep_next = pll_sleep_reg;
		prescale_next  = prescale_reg;
		cp_next        = cp_reg;
		coarse_next    = coarse_reg;
		ref_div_next   = ref_div_reg;
		fifo_ofs_next  = fifo_ofs_reg;
		alarm_next     = alarm_reg;
		rdata_next     = '0;
		// Mode decode; read sync select is ignored while the FIFO is off
		if (!fifo_use_reg)
			mode = MODE_BYPASS;
		else if (rd_sel_reg[SEL_OUTPUT_STROBE])
			mode = MODE_DUAL;
		else
			mode = MODE_SINGLE;
		// Sample clock tick; both PLL paths deliver one tick per sample period
		prediv_next   = (prediv_reg == SAMPLE_DIV) ? 4'h0 : prediv_reg + 4'h1;
		tick_next     = (prediv_reg == SAMPLE_DIV);
		// Internal output strobe from the M divider at detector rate
		m_cnt_next    = m_cnt_reg;
		output_strobe_int_next = output_strobe_int_reg;
		if (tick_reg) begin
			m_cnt_next    = (m_cnt_reg + 8'h01 >= ref_div_reg) ? 8'h00 : m_cnt_reg + 8'h01;
			output_strobe_int_next = (m_cnt_reg == 8'h00);
		end
		// Write side: strobes latched only on data clock rising edges
		dclk_d_next = dclk_s;
		dclk_rise   = dclk_s && !dclk_d_reg;
		wr_strobe   = (mode == MODE_DUAL) ?
			(wr_sel_reg[SEL_FRAME] ? frame_s : sync_s) :
			(rd_sel_reg[SEL_FRAME] ? frame_s : sync_s);
		wr_sync     = dclk_rise && wr_strobe && !wstb_d_reg && (mode != MODE_BYPASS);
		wstb_d_next = dclk_rise ? wr_strobe : wstb_d_reg;
		wr_ptr_next = wr_ptr_reg;
		if (wr_sync)
			wr_ptr_next = '0;
		else if (dclk_rise && mode != MODE_BYPASS)
			wr_ptr_next = wr_ptr_reg + 3'h1;
		// Single source: read reset waits for the next sample tick, so it may slip
		rd_pend_next = rd_pend_reg;
		if (mode == MODE_SINGLE && wr_sync)
			rd_pend_next = 1'b1;
		else if (tick_reg)
			rd_pend_next = 1'b0;
		rd_strobe   = pll_path_reg ? output_strobe_int_reg : output_strobe_ext_s;
		rstb_d_next = tick_reg ? rd_strobe : rstb_d_reg;
		rd_sync     = tick_reg && ((mode == MODE_SINGLE && rd_pend_reg) ||
			(mode == MODE_DUAL && rd_strobe && !rstb_d_reg));
		rd_ptr_next = rd_ptr_reg;
		out_next    = out_reg;
		valid_next  = tick_reg;
		msync_next  = rd_sync;
		if (mode == MODE_BYPASS) begin
			out_next = tick_reg ? data_s : out_reg;
		end else if (rd_sync) begin
			rd_ptr_next = fifo_ofs_reg;
		end else if (tick_reg) begin
			out_next    = mem[rd_ptr_reg];
			rd_ptr_next = rd_ptr_reg + 3'h1;
		end
		// Pointer gap alarms, sampled once per read
		gap = wr_ptr_reg - rd_ptr_reg;
		if (reg_wr_i && reg_addr_i == ADDR_ALARM)
			alarm_next = alarm_reg & ~reg_wdata_i[2:0];
		if (tick_reg && mode != MODE_BYPASS) begin
			if (gap == 3'h0)
				alarm_next[ALM_COLLIDE] = 1'b1;
			if (gap == GAP_ONE || gap == 3'h0 - GAP_ONE)
				alarm_next[ALM_ONE] = 1'b1;
			if (gap == GAP_TWO || gap == 3'h0 - GAP_TWO)
				alarm_next[ALM_TWO] = 1'b1;
		end
		// Register writes
		if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_GEN_CFG0: fifo_use_next = reg_wdata_i[FIFO_USE_BIT];
				ADDR_SYNC_CFG: begin
					rd_sel_next = reg_wdata_i[RD_SEL_LSB +: 4];
					wr_sel_next = reg_wdata_i[WR_SEL_LSB +: 4];
				end
				ADDR_PLL_CFG1: begin
					pll_path_next = reg_wdata_i[PLL_PATH_BIT];
					prescale_next = reg_wdata_i[PRESCALE_LSB +: 3];
					cp_next       = reg_wdata_i[CP_LSB +: 2];
				end
				ADDR_PLL_CFG2: begin
					pll_sleep_next = reg_wdata_i[PLL_SLEEP_BIT];
					coarse_next    = reg_wdata_i[COARSE_LSB +: 6];
				end
				ADDR_REF_DIV:  ref_div_next  = reg_wdata_i[7:0];
				ADDR_FIFO_OFS: fifo_ofs_next = reg_wdata_i[2:0];
				default: ;
			endcase
		end
		// Register reads, answered in the next cycle
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_GEN_CFG0: rdata_next[FIFO_USE_BIT] = fifo_use_reg;
				ADDR_SYNC_CFG: rdata_next[7:0] = {wr_sel_reg, rd_sel_reg};
				ADDR_PLL_CFG1: begin
					rdata_next[PLL_PATH_BIT]        = pll_path_reg;
					rdata_next[PRESCALE_LSB +: 3]   = prescale_reg;
					rdata_next[CP_LSB +: 2]         = cp_reg;
					rdata_next[LFVOLT_LSB +: LFV_W] = lfv_s;
				end
				ADDR_PLL_CFG2: begin
					rdata_next[PLL_SLEEP_BIT]   = pll_sleep_reg;
					rdata_next[COARSE_LSB +: 6] = coarse_reg;
				end
				ADDR_REF_DIV:  rdata_next[7:0] = ref_div_reg;
				ADDR_FIFO_OFS: rdata_next[2:0] = fifo_ofs_reg;
				ADDR_ALARM:    rdata_next[2:0] = alarm_reg;
				default:       rdata_next      = '0;
			endcase
		end
	end

	// FIFO storage written on data clock edges; bypass leaves it untouched
	always_ff @(posedge core_clk_i) begin
		if (dclk_rise && mode != MODE_BYPASS)
			mem[wr_sync ? 3'h0 : wr_ptr_reg] <= data_s;
	end

	// Register all state
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fifo_use_reg  <= 1'b1;
			rd_sel_reg    <= RST_RD_SEL;
			wr_sel_reg    <= RST_WR_SEL;
			pll_path_reg  <= 1'b0;
			pll_sleep_reg <= 1'b1;
			prescale_reg  <= RST_PRESCALE;
			cp_reg        <= CP_SINGLE;
			coarse_reg    <= '0;
			ref_div_reg   <= RST_REF_DIV;
			fifo_ofs_reg  <= RST_FIFO_OFS;
			alarm_reg     <= '0;
			rdata_reg     <= '0;
			prediv_reg    <= '0;
			tick_reg      <= 1'b0;
			m_cnt_reg     <= '0;
			output_strobe_int_reg  <= 1'b0;
			dclk_d_reg    <= 1'b0;
			wstb_d_reg    <= 1'b0;
			rstb_d_reg    <= 1'b0;
			rd_pend_reg   <= 1'b0;
			wr_ptr_reg    <= '0;
			rd_ptr_reg    <= RST_FIFO_OFS;
			out_reg       <= '0;
			valid_reg     <= 1'b0;
			msync_reg     <= 1'b0;
			prescale_div_o <= 4'h4;
		end else begin
			fifo_use_reg  <= fifo_use_next;
			rd_sel_reg    <= rd_sel_next;
			wr_sel_reg    <= wr_sel_next;
			pll_path_reg  <= pll_path_next;
			pll_sleep_reg <= pll_sleep_next;
			prescale_reg  <= prescale_next;
			cp_reg        <= cp_next;
			coarse_reg    <= coarse_next;
			ref_div_reg   <= ref_div_next;
			fifo_ofs_reg  <= fifo_ofs_next;
			alarm_reg     <= alarm_next;
			rdata_reg     <= rdata_next;
			prediv_reg    <= prediv_next;
			tick_reg      <= tick_next;
			m_cnt_reg     <= m_cnt_next;
			output_strobe_int_reg  <= output_strobe_int_next;
			dclk_d_reg    <= dclk_d_next;
			wstb_d_reg    <= wstb_d_next;
			rstb_d_reg    <= rstb_d_next;
			rd_pend_reg   <= rd_pend_next;
			wr_ptr_reg    <= wr_ptr_next;
			rd_ptr_reg    <= rd_ptr_next;
			out_reg       <= out_next;
			valid_reg     <= valid_next;
			msync_reg     <= msync_next;
			prescale_div_o <= prescale_decode(prescale_reg);
		end
	end

	// Outputs straight from flops
	assign reg_rdata_o          = rdata_reg;
	assign pll_path_sel_o       = pll_path_reg;
	assign pll_power_down_o     = pll_sleep_reg;
	assign charge_pump_select_o = cp_reg;
	assign coarse_tune_o        = coarse_reg;
	assign ref_div_o            = ref_div_reg;
	assign sample_data_o        = out_reg;
	assign sample_valid_o       = valid_reg;
	assign mixer_sync_o         = msync_reg;

	// ==========================================================
	// Checks
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n);

	property p_bypass_no_sync;
		(mode == MODE_BYPASS) |=> !mixer_sync_o;
	endproperty
	a_bypass_no_sync: assert property (p_bypass_no_sync) else $error("sync leaked in bypass");
	property p_bypass_ptr_hold;
		(mode == MODE_BYPASS) ##1 (mode == MODE_BYPASS) |-> $stable(wr_ptr_reg);
	endproperty
	a_bypass_ptr_hold: assert property (p_bypass_ptr_hold) else $error("pointer moved in bypass");
	property p_wr_step;
		!wr_sync |=> (wr_ptr_reg == $past(wr_ptr_reg)) || (wr_ptr_reg == $past(wr_ptr_reg) + 3'h1);
	endproperty
	a_wr_step: assert property (p_wr_step) else $error("write pointer jumped");
	property p_single_rd_follows;
		(mode == MODE_SINGLE && wr_sync) |-> ##[1:17] mixer_sync_o;
	endproperty
	a_single_rd_follows: assert property (p_single_rd_follows) else $error("read reset lost");
	property p_rd_reset_pos;
		rd_sync && mode != MODE_BYPASS |=> rd_ptr_reg == $past(fifo_ofs_reg);
	endproperty
	a_rd_reset_pos: assert property (p_rd_reset_pos) else $error("read pointer reset wrong");
	property p_collide;
		tick_reg && mode != MODE_BYPASS && gap == 3'h0 |=> alarm_reg[ALM_COLLIDE];
	endproperty
	a_collide: assert property (p_collide) else $error("collision alarm missed");
	property p_two_apart;
		tick_reg && mode != MODE_BYPASS && (gap == GAP_TWO || gap == 3'h0 - GAP_TWO) |=>
			alarm_reg[ALM_TWO];
	endproperty
	a_two_apart: assert property (p_two_apart) else $error("two-apart alarm missed");
	property p_prescale;
		prescale_reg == 3'h7 ##1 prescale_reg == 3'h7 |-> prescale_div_o == 4'h8;
	endproperty
	a_prescale: assert property (p_prescale) else $error("prescale decode wrong");
	property p_int_strobe_rate;
		pll_path_reg && ref_div_reg == 8'h08 && $rose(output_strobe_int_reg) |->
			##128 ($rose(output_strobe_int_reg) || !pll_path_reg || ref_div_reg != 8'h08);
	endproperty
	a_int_strobe_rate: assert property (p_int_strobe_rate) else $error("internal strobe missing");
endmodule

// [hdl/cmfs_pkg.sv]
// Purpose: Constants, register map and modes of the clock mode and FIFO sync control
// Assumes: One 125 MHz core clock; 16-bit plain register port
// Notes:   Every offset and field position lives here, with the select, prescale, pump, divider and offset reset values
package cmfs_pkg;
	// ==========================================================
	// Register offsets (byte addresses on the 8-bit port)
	localparam logic [7:0]  ADDR_GEN_CFG0   = 8'h00; // general_config_zero
	localparam logic [7:0]  ADDR_SYNC_CFG   = 8'h04; // sync_source_config
	localparam logic [7:0]  ADDR_PLL_CFG1   = 8'h08; // pll_config_first
	localparam logic [7:0]  ADDR_PLL_CFG2   = 8'h0C; // pll_config_second
	localparam logic [7:0]  ADDR_REF_DIV    = 8'h10; // reference divider M
	localparam logic [7:0]  ADDR_FIFO_OFS   = 8'h14; // read pointer reset position
	localparam logic [7:0]  ADDR_ALARM      = 8'h18; // sticky alarms, write 1 to clear
	// ==========================================================
	// Field positions
	localparam int          FIFO_USE_BIT    = 0;
	localparam int          RD_SEL_LSB      = 0;     // read pointer sync select [3:0]
	localparam int          WR_SEL_LSB      = 4;     // write pointer sync select [7:4]
	localparam int          SEL_SYNC        = 0;
	localparam int          SEL_FRAME       = 1;
	localparam int          SEL_OUTPUT_STROBE        = 2;
	localparam int          PLL_PATH_BIT    = 0;
	localparam int          PRESCALE_LSB    = 1;     // [3:1]
	localparam int          CP_LSB          = 4;     // [5:4]
	localparam int          LFVOLT_LSB      = 6;     // [8:6], read only
	localparam int          COARSE_LSB      = 0;     // [5:0]
	localparam int          PLL_SLEEP_BIT   = 6;
	localparam int          ALM_COLLIDE     = 0;
	localparam int          ALM_ONE         = 1;
	localparam int          ALM_TWO         = 2;
	// ==========================================================
	// Reset values
	localparam logic [3:0]  RST_RD_SEL      = 4'h1;  // single source from sync strobe
	localparam logic [3:0]  RST_WR_SEL      = 4'h1;
	localparam logic [2:0]  RST_PRESCALE    = 3'h4;
	localparam logic [1:0]  CP_SINGLE       = 2'h1;
	localparam logic [1:0]  CP_DOUBLE       = 2'h3;
	localparam logic [7:0]  RST_REF_DIV     = 8'h04;
	localparam logic [2:0]  RST_FIFO_OFS    = 3'h4;
	// ==========================================================
	// Sizes and timing
	localparam int          DATA_W          = 32;
	localparam int          REG_W           = 16;
	localparam int          PTR_W           = 3;     // eight-entry FIFO
	localparam int          FIFO_DEPTH      = 8;
	localparam int          LFV_W           = 3;
	localparam int          SYNC_W          = 4 + DATA_W + LFV_W;
	localparam logic [3:0]  SAMPLE_DIV      = 4'hF;  // sample tick every 16 core cycles
	localparam logic [2:0]  GAP_ONE         = 3'h1;
	localparam logic [2:0]  GAP_TWO         = 3'h2;
	// ==========================================================
	// FIFO operating modes
	typedef enum logic [1:0] {MODE_BYPASS, MODE_SINGLE, MODE_DUAL} cmfs_mode_t;
endpackage
